// ---- logic/rtcc_ctrl.v ----

`include "rtcc_regs.vh"

module rtcc_ctrl #(
    parameter OSC_STOP_CYC = `RTCC_OSC_STOP_CYC
) (
    // Clock and reset.
    input  wire       clk,
    input  wire       srst,
    // Register port from the serial protocol engine.
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    output wire [7:0] reg_rdata,
    // Timekeeping side.
    input  wire       seconds_written,
    input  wire       alarm_one_match,
    input  wire       alarm_two_match,
    // Crystal oscillator and supply monitor.
    input  wire       osc_clk,
    input  wire       power_fail,
    output wire       osc_run,
    // Square-wave/interrupt open-drain pin.
    output wire       square_wave_irq_pin_out,
    output wire       square_wave_irq_pin_oe_n,
    // Charger path control.
    output wire       charger_enable,
    output wire       charger_diode,
    output wire [1:0] charger_resistor
);

    // Decodes a register offset.
    function addr_is;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            addr_is = (addr == ofs);
        end
    endfunction

    localparam [15:0] STOP_CYC = OSC_STOP_CYC[15:0];

    reg [7:0]             ctrl_ff;
    reg [7:0]             nxt_ctrl;
    reg [7:0]             flags_ff;
    reg [7:0]             nxt_flags;
    reg [7:0]             charger_ff;
    reg [7:0]             rdata_ff;
    reg [7:0]             nxt_rdata;
    reg [2:0]             osc_sync_ff;
    reg [1:0]             pf_sync_ff;
    reg [`RTCC_DIV_W-1:0] div_ff;
    reg [15:0]            idle_cnt_ff;
    reg                   stopped_ff;
    reg                   osc_run_ff;
    reg                   pin_oe_n_ff;
    reg                   nxt_pin_oe_n;
    reg                   chg_en_ff;
    reg                   chg_diode_ff;
    reg [1:0]             chg_res_ff;
    reg                   sq_level;
    reg                   irq_active;
    reg [7:0]             nxt_charger;
    reg [`RTCC_DIV_W-1:0] nxt_div;
    reg [15:0]            nxt_idle_cnt;
    reg                   nxt_stopped;
    reg                   nxt_osc_run;
    reg                   nxt_chg_en;
    reg                   nxt_chg_diode;
    reg [1:0]             nxt_chg_res;
    reg                   pin_out_ff;

    wire wr_ctrl    = reg_wr & addr_is(reg_addr, `RTCC_OFS_CTRL);
    wire wr_flags   = reg_wr & addr_is(reg_addr, `RTCC_OFS_FLAGS);
    wire wr_charger = reg_wr & addr_is(reg_addr, `RTCC_OFS_CHARGER);

    // Oscillator level after the two-stage synchroniser and its rising edge.
    wire osc_lvl  = osc_sync_ff[1];
    wire osc_rise = osc_sync_ff[1] & ~osc_sync_ff[2];
    wire pf_lvl   = pf_sync_ff[1];

    // Oscillator-stop event: disable bit going 0 to 1, or edges ceasing.
    wire disable_rise = wr_ctrl & reg_wdata[`RTCC_CTRL_OSC_DIS] & ~ctrl_ff[`RTCC_CTRL_OSC_DIS];
    // The timeout must exceed one crystal period or a running crystal reads as stopped.
    wire idle_expired = (idle_cnt_ff == STOP_CYC - 16'h0001);
    wire stop_event   = disable_rise | (idle_expired & ~stopped_ff);

    // Crystal clock synchroniser; the third stage only remembers the last level.
    always @(posedge clk) begin
        if (srst) begin
            osc_sync_ff <= 3'h0;
        end else begin
            osc_sync_ff <= {osc_sync_ff[1:0], osc_clk};
        end
    end

    // Supply-monitor synchroniser.
    always @(posedge clk) begin
        if (srst) begin
            pf_sync_ff <= 2'h0;
        end else begin
            pf_sync_ff <= {pf_sync_ff[0], power_fail};
        end
    end

    // Control register.
    always @* begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctrl) begin
            nxt_ctrl = reg_wdata & `RTCC_CTRL_WMASK;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            ctrl_ff <= `RTCC_CTRL_RESET;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Oscillator enable output follows the inverted disable bit.
    // Taken from the next control value so the enable changes with the register.
    always @* begin
        nxt_osc_run = ~nxt_ctrl[`RTCC_CTRL_OSC_DIS];
    end

    always @(posedge clk) begin
        if (srst) begin
            osc_run_ff <= 1'b1;
        end else begin
            osc_run_ff <= nxt_osc_run;
        end
    end

    // Edge-loss watchdog: counts clocks since the last rising oscillator edge.
    always @* begin
        nxt_idle_cnt = idle_cnt_ff;
        nxt_stopped  = stopped_ff;
        if (osc_rise) begin
            nxt_idle_cnt = 16'h0000;
            nxt_stopped  = 1'b0;
        end else if (idle_expired) begin
            nxt_stopped  = 1'b1;
        end else begin
            nxt_idle_cnt = idle_cnt_ff + 16'h0001;
        end
    end

    // The count parks at its end so that one stop gives one flag event.
    always @(posedge clk) begin
        if (srst) begin
            idle_cnt_ff <= 16'h0000;
            stopped_ff  <= 1'b1;
        end else begin
            idle_cnt_ff <= nxt_idle_cnt;
            stopped_ff  <= nxt_stopped;
        end
    end

    // Status flags: hardware set wins over a clearing write.
    always @* begin
        nxt_flags = flags_ff;
        if (wr_flags) begin
            nxt_flags = flags_ff & reg_wdata & `RTCC_FLAGS_WMASK;
        end
        if (stop_event) begin
            nxt_flags[`RTCC_FLAG_OSC_HALT] = 1'b1;
        end
        if (alarm_one_match) begin
            nxt_flags[`RTCC_FLAG_ALARM1] = 1'b1;
        end
        if (alarm_two_match) begin
            nxt_flags[`RTCC_FLAG_ALARM2] = 1'b1;
        end
    end

    // Power-up leaves the halted flag set: the crystal has not yet run.
    always @(posedge clk) begin
        if (srst) begin
            flags_ff <= `RTCC_FLAGS_RESET;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // Charger configuration register.
    always @* begin
        nxt_charger = charger_ff;
        if (wr_charger) begin
            nxt_charger = reg_wdata & `RTCC_CHARGER_WMASK;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            charger_ff <= `RTCC_CHARGER_RESET;
        end else begin
            charger_ff <= nxt_charger;
        end
    end

    // Charger decode from the stored configuration.
    wire       key_open  = (charger_ff[`RTCC_CHG_KEY_HI:`RTCC_CHG_KEY_LO] == `RTCC_CHG_KEY_OPEN);
    wire [1:0] diode_sel = charger_ff[3:2];
    wire [1:0] res_sel   = charger_ff[1:0];
    wire       diode_ok  = (diode_sel == `RTCC_DIODE_NONE) | (diode_sel == `RTCC_DIODE_ONE);
    wire       res_ok    = (res_sel != `RTCC_RES_OFF);

    // The outputs lag the stored configuration by one clock.
    // An invalid diode field also forces the resistor output off.
    always @* begin
        nxt_chg_en    = key_open & diode_ok & res_ok;
        nxt_chg_diode = key_open & (diode_sel == `RTCC_DIODE_ONE);
        nxt_chg_res   = `RTCC_RES_OFF;
        if (key_open & diode_ok) begin
            nxt_chg_res = res_sel;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            chg_en_ff    <= 1'b0;
            chg_diode_ff <= 1'b0;
            chg_res_ff   <= `RTCC_RES_OFF;
        end else begin
            chg_en_ff    <= nxt_chg_en;
            chg_diode_ff <= nxt_chg_diode;
            chg_res_ff   <= nxt_chg_res;
        end
    end

    // Divider of crystal edges; a seconds write restarts the count.
    // Bit 14 stays low for the first half second after a restart, so the wave rises 500ms in.
    always @* begin
        nxt_div = div_ff;
        if (seconds_written) begin
            nxt_div = {`RTCC_DIV_W{1'b0}};
        end else if (osc_rise) begin
            nxt_div = div_ff + {{(`RTCC_DIV_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            div_ff <= {`RTCC_DIV_W{1'b0}};
        end else begin
            div_ff <= nxt_div;
        end
    end

    // Square-wave level for the selected rate.
    always @* begin
        case (ctrl_ff[`RTCC_CTRL_RATE_HI:`RTCC_CTRL_RATE_LO])
            `RTCC_RATE_1HZ: sq_level = div_ff[`RTCC_DIV_BIT_1HZ];
            `RTCC_RATE_4K:  sq_level = div_ff[`RTCC_DIV_BIT_4K];
            `RTCC_RATE_8K:  sq_level = div_ff[`RTCC_DIV_BIT_8K];
            default:        sq_level = osc_lvl;
        endcase
    end

    // Interrupt request from enabled alarm flags.
    always @* begin
        irq_active = ctrl_ff[`RTCC_CTRL_IRQ_MODE] &
                     ((flags_ff[`RTCC_FLAG_ALARM1] & ctrl_ff[`RTCC_CTRL_A1_IRQ_EN]) |
                      (flags_ff[`RTCC_FLAG_ALARM2] & ctrl_ff[`RTCC_CTRL_A2_IRQ_EN]));
    end

    // Open-drain pin: pulled low for a low square-wave phase or an active interrupt, unless power fails with backup output off.
    always @* begin
        if (pf_lvl & ~ctrl_ff[`RTCC_CTRL_BKP_OUT_EN]) begin
            nxt_pin_oe_n = 1'b1;
        end else if (ctrl_ff[`RTCC_CTRL_IRQ_MODE]) begin
            nxt_pin_oe_n = ~irq_active;
        end else begin
            nxt_pin_oe_n = sq_level;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            pin_oe_n_ff <= 1'b1;
        end else begin
            pin_oe_n_ff <= nxt_pin_oe_n;
        end
    end

    // Open-drain pin: the driven level is always low, only the enable moves.
    always @(posedge clk) begin
        if (srst) begin
            pin_out_ff <= 1'b0;
        end else begin
            pin_out_ff <= 1'b0;
        end
    end

    // Registered read data; unmapped offsets read zero.
    always @* begin
        if (addr_is(reg_addr, `RTCC_OFS_CTRL)) begin
            nxt_rdata = ctrl_ff;
        end else if (addr_is(reg_addr, `RTCC_OFS_FLAGS)) begin
            nxt_rdata = flags_ff;
        end else if (addr_is(reg_addr, `RTCC_OFS_CHARGER)) begin
            nxt_rdata = charger_ff;
        end else begin
            nxt_rdata = 8'h00;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata                = rdata_ff;
    assign osc_run                  = osc_run_ff;
    assign square_wave_irq_pin_out  = pin_out_ff;
    assign square_wave_irq_pin_oe_n = pin_oe_n_ff;
    assign charger_enable           = chg_en_ff;
    assign charger_diode            = chg_diode_ff;
    assign charger_resistor         = chg_res_ff;

endmodule // rtcc_ctrl

// ---- logic/rtcc_regs.vh ----
`ifndef RTCC_REGS_VH
`define RTCC_REGS_VH

// Register offsets on the register port.
`define RTCC_OFS_CTRL          8'h0e
`define RTCC_OFS_FLAGS         8'h0f
`define RTCC_OFS_CHARGER       8'h10

// Field positions of oscillator_output_control.
`define RTCC_CTRL_OSC_DIS      7
`define RTCC_CTRL_BKP_OUT_EN   5
`define RTCC_CTRL_RATE_HI      4
`define RTCC_CTRL_RATE_LO      3
`define RTCC_CTRL_IRQ_MODE     2
`define RTCC_CTRL_A2_IRQ_EN    1
`define RTCC_CTRL_A1_IRQ_EN    0

// Writable bits; the remaining bits read as zero.
`define RTCC_CTRL_WMASK        8'hbf
`define RTCC_FLAGS_WMASK       8'h83
`define RTCC_CHARGER_WMASK     8'hff

// Field positions of oscillator_alarm_flags.
`define RTCC_FLAG_OSC_HALT     7
`define RTCC_FLAG_ALARM2       1
`define RTCC_FLAG_ALARM1       0

// Fields and codes of backup_charger_config.
`define RTCC_CHG_KEY_HI        7
`define RTCC_CHG_KEY_LO        4
`define RTCC_CHG_KEY_OPEN      4'ha
`define RTCC_DIODE_NONE        2'h1
`define RTCC_DIODE_ONE         2'h2
`define RTCC_RES_OFF           2'h0

// Reset values at first power-up.
`define RTCC_CTRL_RESET        8'h18
`define RTCC_FLAGS_RESET       8'h80
`define RTCC_CHARGER_RESET     8'h00

// Rate select codes.
`define RTCC_RATE_1HZ          2'h0
`define RTCC_RATE_4K           2'h1
`define RTCC_RATE_8K           2'h2
`define RTCC_RATE_32K          2'h3

// Oscillator divider: 15 bits count one second of crystal edges.
`define RTCC_DIV_W             15
`define RTCC_DIV_BIT_1HZ       14
`define RTCC_DIV_BIT_4K        2
`define RTCC_DIV_BIT_8K        1

// Timing: system clock period and oscillator-stop detection time.
`define RTCC_CLK_PERIOD_NS     50
`define RTCC_OSC_STOP_NS       122070
`define RTCC_OSC_STOP_CYC      (`RTCC_OSC_STOP_NS / `RTCC_CLK_PERIOD_NS)

`endif

// ---- verif/rtcc_ctrl_monitor.sv ----
module rtcc_mon (
    // Clock and reset.
    input logic       clk,
    input logic       srst,
    // Register port, alarm-one input and block outputs.
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic       reg_wr,
    input logic [7:0] reg_rdata,
    input logic       alarm_one_match,
    input logic       osc_run,
    input logic       square_wave_irq_pin_oe_n,
    input logic       charger_enable,
    input logic       charger_diode,
    input logic [1:0] charger_resistor
);
    timeunit 1ns / 1ns;
    wire        wc = reg_wr && reg_addr == 8'h0e;
    wire        wt = reg_wr && reg_addr == 8'h10;
    wire        rf = !reg_wr && reg_addr == 8'h0f;
    wire [3:0]  wk = reg_wdata[7:4];
    logic [7:0] pa;
    always @(posedge clk) pa <= reg_addr;
    // Bits that must read as zero for the offset shown on the read port.
    wire [7:0]  zm = pa == 8'h0e ? 8'h40 : pa == 8'h0f ? 8'h7c : pa == 8'h10 ? 8'h00 : 8'hff;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property p_osc; wc |=> osc_run == !$past(reg_wdata[7]); endproperty
    a_osc: assert property (p_osc) else $error("osc_run does not follow the disable bit");
    property p_zero; (reg_rdata & zm) == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("fixed zero bit reads one");
    property p_chg; wt |-> ##2 charger_enable == ($past(wk, 2) == 4'ha && ^$past(reg_wdata[3:2], 2)
        && |$past(reg_wdata[1:0], 2)); endproperty
    a_chg: assert property (p_chg) else $error("charger enable decode wrong");
    property p_sel; wt && wk == 4'ha && ^reg_wdata[3:2] && |reg_wdata[1:0]
        |-> ##2 charger_diode == $past(reg_wdata[3], 2) && charger_resistor == $past(reg_wdata[1:0], 2); endproperty
    a_sel: assert property (p_sel) else $error("charger diode or resistor wrong");
    property p_rst; $fell(srst) |-> osc_run && square_wave_irq_pin_oe_n && !charger_enable && reg_rdata == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs wrong after reset");
    property p_rel; wc && reg_wdata[2:0] == 3'h4 |-> ##2 square_wave_irq_pin_oe_n; endproperty
    a_rel: assert property (p_rel) else $error("pin asserted with alarms masked");
    property p_a1; alarm_one_match ##1 !reg_wr ##1 rf |=> reg_rdata[0]; endproperty
    a_a1: assert property (p_a1) else $error("alarm one flag not set");
    property p_osf; wc && reg_wdata[7] ##1 !reg_wr ##1 rf |=> reg_rdata[7]; endproperty
    a_osf: assert property (p_osf) else $error("halted flag not set by disable");
    c_key: cover property (wt && wk == 4'ha);
    c_a1: cover property (alarm_one_match);
    c_stop: cover property ($fell(osc_run));
endmodule // rtcc_mon

bind rtcc_ctrl rtcc_mon i_mon (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .alarm_one_match,
    .osc_run, .square_wave_irq_pin_oe_n, .charger_enable, .charger_diode, .charger_resistor);

// ---- verif/rtcc_host.sv ----
module rtcc_host (
    // Clock and crystal hold.
    input  logic       clk,
    input  logic       osc_stop,
    // Register port and crystal clock toward the block.
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic       reg_wr,
    output logic       osc_clk
);
    timeunit 1ns / 1ns;
    initial begin
        {reg_addr, reg_wdata, reg_wr, osc_clk} = 0;
        #7;
        // A stopped crystal freezes its level, as a halted oscillator does.
        forever #200 if (!osc_stop) osc_clk = ~osc_clk;
    end
    task wr(input logic [7:0] a, d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge clk);
        reg_wr <= 0;
        reg_wdata <= ~d;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
    endtask
endmodule // rtcc_host

// ---- verif/rtcc_ctrl_test.sv ----
module rtcc_ctrl_test;
    timeunit 1ns / 1ns;
    logic       clk = 0, srst = 1, due = 0, osc_stop = 0, prev = 0, ok;
    logic       seconds_written = 0, alarm_one_match = 0, alarm_two_match = 0, power_fail = 0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, lf = 8'h18, v;
    logic       reg_wr, osc_clk, osc_run, square_wave_irq_pin_out, square_wave_irq_pin_oe_n;
    logic       charger_enable, charger_diode;
    logic [1:0] charger_resistor;
    logic [7:0] q[$];
    int         n_errors = 0, num_checks = 0, cyc = 0, cnt, ex;
    rtcc_host i_host (.clk, .osc_stop, .reg_addr, .reg_wdata, .reg_wr, .osc_clk);
    rtcc_ctrl #(.OSC_STOP_CYC(40)) i_dut (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
        .seconds_written, .alarm_one_match, .alarm_two_match, .osc_clk, .power_fail, .osc_run,
        .square_wave_irq_pin_out, .square_wave_irq_pin_oe_n, .charger_enable, .charger_diode, .charger_resistor);
    initial begin
        forever #25 clk = ~clk;
    end
    task end_sim;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task check(input string nm, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task rd(input logic [7:0] a, e);
        q.push_back(e);
        i_host.rd(a);
        due <= 1;
        @(posedge clk);
        due <= 0;
    endtask
    task pin(input logic e);
        repeat (4) @(posedge clk);
        #1;
        check("pin", {7'h0, square_wave_irq_pin_oe_n}, {7'h0, e});
    endtask
    function logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    always @(posedge clk) begin
        if (due) check("rdata", reg_rdata, q.pop_front());
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        srst <= 0;
        rd(8'h0e, 8'h18);
        rd(8'h0f, 8'h80);
        rd(8'h10, 8'h00);
        rd(8'h11, 8'h00);
        i_host.wr(8'h0f, 8'hff);
        rd(8'h0f, 8'h80);
        i_host.wr(8'h0f, 8'h00);
        rd(8'h0f, 8'h00);
        i_host.wr(8'h0e, 8'hff);
        rd(8'h0f, 8'h80);
        rd(8'h0e, 8'hbf);
        check("run", {7'h0, osc_run}, 8'h0);
        $display("Test control done");
        i_host.wr(8'h0e, 8'h07);
        i_host.wr(8'h0f, 8'h00);
        @(posedge clk) alarm_one_match <= 1;
        @(posedge clk) alarm_one_match <= 0;
        pin(0);
        i_host.wr(8'h0f, 8'h7d);
        rd(8'h0f, 8'h01);
        @(posedge clk) power_fail <= 1;
        pin(1);
        i_host.wr(8'h0e, 8'h27);
        pin(0);
        @(posedge clk) power_fail <= 0;
        i_host.wr(8'h0e, 8'h06);
        pin(1);
        @(posedge clk) alarm_two_match <= 1;
        @(posedge clk) alarm_two_match <= 0;
        pin(0);
        rd(8'h0f, 8'h03);
        i_host.wr(8'h0f, 8'h02);
        rd(8'h0f, 8'h02);
        i_host.wr(8'h0e, 8'h04);
        pin(1);
        $display("Test alarm done");
        @(posedge clk) osc_stop <= 1;
        i_host.wr(8'h0f, 8'h00);
        repeat (60) @(posedge clk);
        rd(8'h0f, 8'h80);
        @(posedge clk) osc_stop <= 0;
        repeat (20) @(posedge clk);
        i_host.wr(8'h0f, 8'h00);
        repeat (60) @(posedge clk);
        rd(8'h0f, 8'h00);
        for (int r = 1; r < 4; r++) begin
            i_host.wr(8'h0e, {3'h0, r[1:0], 3'h0});
            cnt = 0;
            // 512 clocks span 64 crystal periods.
            ex = (r == 3) ? 64 : 4 << r;
            repeat (512) begin
                @(posedge clk);
                if (square_wave_irq_pin_oe_n === 1'b1 && prev === 1'b0) cnt++;
                prev = square_wave_irq_pin_oe_n;
            end
            check("rate", {7'h0, cnt >= ex - 1 && cnt <= ex + 1}, 8'h1);
        end
        i_host.wr(8'h0e, 8'h00);
        @(posedge clk) seconds_written <= 1;
        @(posedge clk) seconds_written <= 0;
        repeat (2000) @(posedge clk);
        pin(0);
        $display("Test wave done");
        for (int i = 0; i < 16; i++) begin
            lf = lfsr(lf);
            v = i[0] ? lf : {4'ha, lf[3:0]};
            i_host.wr(8'h10, v);
            @(posedge clk);
            #1;
            ok = v[7:4] == 4'ha && ^v[3:2];
            check("en", {7'h0, charger_enable}, {7'h0, ok && |v[1:0]});
            check("diode", {7'h0, charger_diode}, {7'h0, ok & v[3]});
            check("res", {6'h0, charger_resistor}, ok ? {6'h0, v[1:0]} : 8'h0);
        end
        rd(8'h10, v);
        @(posedge clk) srst <= 1;
        repeat (3) @(posedge clk);
        srst <= 0;
        rd(8'h10, 8'h00);
        $display("Test charger done");
        end_sim();
    end
endmodule // rtcc_ctrl_test
